// file: core/pcs_pkg.sv
// Package: constants, types and register map for the program counter and return stack
package pcs_pkg;

  // ********************
  // Widths
  // ********************
  localparam int PC_W    = 15;
  localparam int SP_W    = 5;
  localparam int DEPTH   = 16;
  localparam int PCH_W   = 7;

  // ********************
  // Register indices (printed offsets are not word aligned)
  // ********************
  localparam logic [11:0] IDX_STACK_INDEX = 12'hFED;
  localparam logic [11:0] IDX_TOP_LOW     = 12'hFEE;
  localparam logic [11:0] IDX_TOP_HIGH    = 12'hFEF;
  localparam logic [11:0] IDX_PC_LOW      = 12'hF82;
  localparam logic [11:0] IDX_PC_LATCH    = 12'hF8A;
  localparam logic [11:0] IDX_CTRL        = 12'hFE0;
  localparam logic [11:0] IDX_STATUS      = 12'hFE1;
  localparam logic [13:0] ADDR_STACK_INDEX = {IDX_STACK_INDEX, 2'b00};
  localparam logic [13:0] ADDR_TOP_LOW     = {IDX_TOP_LOW, 2'b00};
  localparam logic [13:0] ADDR_TOP_HIGH    = {IDX_TOP_HIGH, 2'b00};
  localparam logic [13:0] ADDR_PC_LOW      = {IDX_PC_LOW, 2'b00};
  localparam logic [13:0] ADDR_PC_LATCH    = {IDX_PC_LATCH, 2'b00};
  localparam logic [13:0] ADDR_CTRL        = {IDX_CTRL, 2'b00};
  localparam logic [13:0] ADDR_STATUS      = {IDX_STATUS, 2'b00};

  // ********************
  // Reset values and fields
  // ********************
  localparam logic [SP_W-1:0] SP_EMPTY = 5'h1F;
  localparam logic [SP_W-1:0] SP_FULL  = 5'h0F;
  localparam logic [3:0]      EMPTY_SHOW = 4'hF;
  localparam int CTRL_FAULT_EN_BIT  = 0;
  localparam int STAT_OVER_BIT      = 0;
  localparam int STAT_UNDER_BIT     = 1;

  // ********************
  // Core operations
  // ********************
  typedef enum logic [3:0] {
    OP_NONE        = 4'h0,
    OP_STEP        = 4'h1,
    OP_CALL        = 4'h2,
    OP_INDIRECT_CALL_OP       = 4'h3,
    OP_BRW         = 4'h4,
    OP_BRA         = 4'h5,
    OP_RETURN      = 4'h6,
    OP_RET_LITERAL = 4'h7,
    OP_RET_INT     = 4'h8,
    OP_INT_VECTOR  = 4'h9,
    OP_PCL_WRITE   = 4'hA
  } pcs_op_e;

  typedef struct packed {
    pcs_op_e     op;
    logic [10:0] operand;
    logic [7:0]  wreg;
    logic [7:0]  result;
    logic [PC_W-1:0] vector;
  } pcs_cmd_s;

  typedef struct packed {
    logic [SP_W-1:0] sp;
    logic            over_flag;
    logic            under_flag;
    logic            fault_rst;
  } pcs_stk_s;

endpackage

// file: core/pcs_core.sv
// Program counter sequencing, 16-entry return stack and APB register slave
//
// Function
// RULE1 - 15-bit counter; low byte visible, high from latch
// RULE2 - Any reset clears whole program counter
// RULE3 - Low byte write loads high bits from latch
// RULE4 - Call: operand low eleven bits, latch bits 6..3
// RULE5 - Indirect call: W low byte, latch high
// RULE6 - Branch by W: counter plus one plus W
// RULE7 - Relative branch: plus one plus signed operand
// RULE8 - Sixteen entries of fifteen bits, separate space
// RULE9 - Push on calls, interrupt; pop on returns
// RULE10 - Push and pop leave high latch untouched
// RULE11 - Fault reset off: stack wraps circularly
// RULE12 - Overflow and underflow flags set regardless
// RULE13 - Stack pointer five bits wide
// RULE14 - Pointer selects entry shown by top registers
// RULE15 - Push increments then writes; pop reads then decrements
// RULE16 - After reset pointer holds 0x1F, empty
// RULE17 - Empty top reads zero or entry 0x0F
// RULE18 - Fault reset on: overflow/underflow resets device
// RULE19 - Overflow: push at 0x0F; underflow: pop at 0x1F
//
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
module pcs_core
  import pcs_pkg::*;
(
  // Clock and reset
  input  wire logic            mclk,
  input  wire logic            reset,
  // Configuration
  input  wire logic            stack_fault_reset_en,
  // Core command
  input  wire pcs_cmd_s        cmd,
  // APB slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [15:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic                 pready,
  output logic [31:0]          prdata,
  output logic                 pslverr,
  // Status
  output logic [PC_W-1:0]      pc,
  output logic [SP_W-1:0]      stack_index,
  output logic                 stack_over_flag,
  output logic                 stack_under_flag,
  output logic                 stack_fault_reset
);

  // ********************
  // State
  // ********************
  typedef struct packed {
    logic [PC_W-1:0]  pc;
    logic [PCH_W-1:0] latch;
    pcs_stk_s         stk;
    logic             ready;
    logic [31:0]      rdata;
    logic             slverr;
    logic             en_meta;
    logic             en_sync;
  } pcs_state_s;

  pcs_state_s            st_ff;
  pcs_state_s            nxt_st;
  logic [PC_W-1:0]       mem_ff [DEPTH];
  logic                  wr_en;
  logic [3:0]            wr_idx;
  logic [PC_W-1:0]       wr_val;

  // ********************
  // Helpers
  // ********************
  logic [PC_W-1:0] pc_inc;
  logic [3:0]      sel_idx;
  logic [PC_W-1:0] top_val;
  logic            sp_empty;
  logic            bus_acc;
  logic [13:0]     byte_addr;
  logic [PC_W-1:0] call_tgt;
  logic [PC_W-1:0] indirect_call_op_tgt;
  logic [PC_W-1:0] pcl_tgt;
  logic [PC_W-1:0] brw_tgt;
  logic [PC_W-1:0] bra_tgt;
  logic            fault_en;

  // Config bit comes from outside the core clock; only the second stage is read
  assign fault_en  = st_ff.en_sync;
  assign pc_inc    = st_ff.pc + 15'h0001;
  assign sp_empty  = (st_ff.stk.sp == SP_EMPTY);
  assign sel_idx   = sp_empty ? EMPTY_SHOW : st_ff.stk.sp[3:0];               // [RULE14]
  // Empty stack shows zero under fault reset, else entry 0x0F
  assign top_val   = (sp_empty && fault_en) ? '0 : mem_ff[sel_idx];             // [RULE17]
  assign bus_acc   = psel && penable && !st_ff.ready;
  assign byte_addr = paddr[13:0];

  // ********************
  // Branch and call targets
  // ********************
  assign call_tgt  = {st_ff.latch[6:3], cmd.operand};                           // [RULE4]
  assign indirect_call_op_tgt = {st_ff.latch, cmd.wreg};                                   // [RULE5]
  assign pcl_tgt   = {st_ff.latch, cmd.result};                                 // [RULE3]
  assign brw_tgt   = pc_inc + {7'h00, cmd.wreg};                                // [RULE6]
  // Full-width add, so 256-location boundaries are crossed freely
  assign bra_tgt   = pc_inc + {{6{cmd.operand[8]}}, cmd.operand[8:0]};          // [RULE7]

  // ********************
  // Next state
  // ********************
  always_comb begin
    logic push;
    logic pop;
    logic [SP_W-1:0] sp_up;
    logic over_evt;
    logic under_evt;
    push   = 1'b0;
    pop    = 1'b0;
    sp_up  = st_ff.stk.sp + 5'h01;
    over_evt  = 1'b0;
    under_evt = 1'b0;
    nxt_st = st_ff;
    wr_en  = 1'b0;
    wr_idx = '0;
    wr_val = '0;
    nxt_st.ready  = 1'b0;
    nxt_st.slverr = 1'b0;
    nxt_st.stk.fault_rst = 1'b0;
    nxt_st.en_meta = stack_fault_reset_en;
    nxt_st.en_sync = st_ff.en_meta;

    unique case (cmd.op)
      OP_STEP: begin
        nxt_st.pc = pc_inc;
      end
      OP_PCL_WRITE: begin
        nxt_st.pc = pcl_tgt;                                                     // [RULE3]
      end
      OP_CALL: begin
        nxt_st.pc = call_tgt;                                                    // [RULE4]
        push = 1'b1;                                                             // [RULE9]
      end
      OP_INDIRECT_CALL_OP: begin
        nxt_st.pc = indirect_call_op_tgt;                                                   // [RULE5]
        push = 1'b1;
      end
      OP_INT_VECTOR: begin
        nxt_st.pc = cmd.vector;
        push = 1'b1;
      end
      OP_BRW: begin
        nxt_st.pc = brw_tgt;                                                     // [RULE6]
      end
      OP_BRA: begin
        nxt_st.pc = bra_tgt;                                                     // [RULE7]
      end
      OP_RETURN, OP_RET_LITERAL, OP_RET_INT: begin
        nxt_st.pc = top_val;                                                     // [RULE15]
        pop = 1'b1;                                                              // [RULE9]
      end
      default: begin
      end
    endcase

    // Latch is never touched by stack traffic
    if (push) begin                                                              // [RULE10]
      // Pointer first, then the saved return address at the new slot
      nxt_st.stk.sp = (sp_up == 5'h10) ? 5'h00 : sp_up;                          // [RULE15] [RULE11]
      wr_en  = 1'b1;                                                             // [RULE8]
      wr_idx = nxt_st.stk.sp[3:0];
      wr_val = pc_inc;
      if (st_ff.stk.sp == SP_FULL) begin                                         // [RULE19]
        over_evt = 1'b1;
        nxt_st.stk.over_flag = 1'b1;                                             // [RULE12]
        nxt_st.stk.fault_rst = fault_en;                                         // [RULE18]
      end
    end
    if (pop) begin
      nxt_st.stk.sp = st_ff.stk.sp - 5'h01;                                      // [RULE13]
      if (sp_empty) begin                                                        // [RULE19]
        nxt_st.stk.sp = SP_FULL;
        under_evt = 1'b1;
        nxt_st.stk.under_flag = 1'b1;                                            // [RULE12]
        nxt_st.stk.fault_rst = fault_en;                                         // [RULE18]
      end
    end

    // APB access; in the same cycle index writes lose to push or pop, top writes to push, PC low writes to any core op
    if (bus_acc) begin
      nxt_st.ready = 1'b1;
      nxt_st.rdata = '0;
      unique case (byte_addr)
        ADDR_STACK_INDEX: begin
          nxt_st.rdata = {27'h0, st_ff.stk.sp};
          if (pwrite && !push && !pop) begin
            nxt_st.stk.sp = pwdata[SP_W-1:0];                                   // [RULE14]
          end
        end
        ADDR_TOP_LOW: begin
          nxt_st.rdata = {24'h0, top_val[7:0]};
          if (pwrite && !push) begin
            wr_en  = 1'b1;
            wr_idx = sel_idx;
            wr_val = {top_val[14:8], pwdata[7:0]};
          end
        end
        ADDR_TOP_HIGH: begin
          nxt_st.rdata = {25'h0, top_val[14:8]};
          if (pwrite && !push) begin
            wr_en  = 1'b1;
            wr_idx = sel_idx;
            wr_val = {pwdata[6:0], top_val[7:0]};
          end
        end
        ADDR_PC_LOW: begin
          nxt_st.rdata = {24'h0, st_ff.pc[7:0]};                                 // [RULE1]
          if (pwrite && cmd.op == OP_NONE) begin
            nxt_st.pc = {st_ff.latch, pwdata[7:0]};                              // [RULE3]
          end
        end
        ADDR_PC_LATCH: begin
          nxt_st.rdata = {25'h0, st_ff.latch};
          if (pwrite) begin
            nxt_st.latch = pwdata[PCH_W-1:0];                                    // [RULE1]
          end
        end
        ADDR_CTRL: begin
          nxt_st.rdata = {31'h0, fault_en};
        end
        ADDR_STATUS: begin
          nxt_st.rdata = {30'h0, st_ff.stk.under_flag, st_ff.stk.over_flag};
          // Write one to clear; a flag raised in the same cycle stays set
          if (pwrite) begin
            nxt_st.stk.over_flag  = (st_ff.stk.over_flag & ~pwdata[STAT_OVER_BIT]) | over_evt;      // [RULE12]
            nxt_st.stk.under_flag = (st_ff.stk.under_flag & ~pwdata[STAT_UNDER_BIT]) | under_evt;   // [RULE12]
          end
        end
        default: begin
          nxt_st.slverr = 1'b1;
        end
      endcase
    end
  end

  // ********************
  // Registers
  // ********************
  // Flags survive a stack-fault reset so software can see its cause
  always_ff @(posedge mclk) begin
    if (reset || st_ff.stk.fault_rst) begin
      st_ff.pc       <= '0;                                                      // [RULE2]
      st_ff.latch    <= '0;
      st_ff.stk.sp   <= SP_EMPTY;                                                // [RULE16]
      st_ff.stk.over_flag  <= reset ? 1'b0 : st_ff.stk.over_flag;
      st_ff.stk.under_flag <= reset ? 1'b0 : st_ff.stk.under_flag;
      st_ff.stk.fault_rst  <= 1'b0;
      st_ff.ready    <= 1'b0;
      st_ff.rdata    <= '0;
      st_ff.slverr   <= 1'b0;
      // Synchroniser keeps running through any reset
      st_ff.en_meta  <= nxt_st.en_meta;
      st_ff.en_sync  <= nxt_st.en_sync;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Stack array has no reset; its contents are unknown until written
  for (genvar gi = 0; gi < DEPTH; gi++) begin : g_entry
    always_ff @(posedge mclk) begin
      if (wr_en && (wr_idx == 4'(gi))) begin
        mem_ff[gi] <= wr_val;
      end
    end
  end

  // ********************
  // Outputs
  // ********************
  assign pready            = st_ff.ready;
  assign prdata            = st_ff.rdata;
  assign pslverr           = st_ff.slverr;
  assign pc                = st_ff.pc;
  assign stack_index       = st_ff.stk.sp;
  assign stack_over_flag   = st_ff.stk.over_flag;
  assign stack_under_flag  = st_ff.stk.under_flag;
  assign stack_fault_reset = st_ff.stk.fault_rst;

endmodule // pcs_core

// file: test/pcs_props.sv
// Checker: counter and return stack properties
`timescale 1ns/100ps
module pcs_props
  import pcs_pkg::*;
(
  // Clock, reset, config
  input wire logic            mclk,
  input wire logic            reset,
  input wire logic            stack_fault_reset_en,
  // Core command
  input wire pcs_cmd_s        cmd,
  // Status
  input wire logic [PC_W-1:0] pc,
  input wire logic [SP_W-1:0] stack_index,
  input wire logic            stack_over_flag,
  input wire logic            stack_under_flag,
  input wire logic            stack_fault_reset
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  logic            calm;
  logic            push;
  logic            pop;
  logic [PC_W-1:0] bra_off;
  // Fault reset off, none pending: targets are plain
  assign calm    = !stack_fault_reset && !stack_fault_reset_en;
  assign push    = cmd.op inside {OP_CALL, OP_INDIRECT_CALL_OP, OP_INT_VECTOR};
  assign pop     = cmd.op inside {OP_RETURN, OP_RET_LITERAL, OP_RET_INT};
  assign bra_off = {{6{cmd.operand[8]}}, cmd.operand[8:0]};
  sequence s_under_reset;
    (stack_fault_reset && stack_under_flag) ##1 (pc == '0 && stack_index == SP_EMPTY);
  endsequence
  a_reset_clears_pc: assert property (disable iff (1'b0) reset |=> pc == '0 && stack_index == SP_EMPTY)
    else $error("pc or pointer not cleared by reset");
  a_call_target: assert property (calm && cmd.op == OP_CALL |=> pc[10:0] == $past(cmd.operand))
    else $error("call target wrong");
  a_indirect_call_op_target: assert property (calm && cmd.op == OP_INDIRECT_CALL_OP |=> pc[7:0] == $past(cmd.wreg))
    else $error("indirect call target wrong");
  a_brw_target: assert property (calm && cmd.op == OP_BRW |=> pc == $past(pc) + 15'h1 + $past(cmd.wreg))
    else $error("branch by w target wrong");
  a_bra_target: assert property (calm && cmd.op == OP_BRA |=> pc == $past(pc) + 15'h1 + $past(bra_off))
    else $error("relative branch target wrong");
  a_push_bumps_pointer: assert property (calm && push && stack_index != SP_FULL |=> stack_index == $past(stack_index) + 5'h01)
    else $error("push did not bump pointer");
  a_over_flag_set: assert property (calm && push && stack_index == SP_FULL |=> stack_over_flag && stack_index == 5'h00)
    else $error("overflow not flagged");
  a_under_fault_reset: assert property (!stack_fault_reset && stack_fault_reset_en && pop && stack_index == SP_EMPTY |=> s_under_reset)
    else $error("underflow fault reset missing");
  sequence s_over_reset;
    (stack_fault_reset && stack_over_flag) ##1 (pc == '0 && stack_index == SP_EMPTY);
  endsequence
  a_over_fault_reset: assert property (!stack_fault_reset && stack_fault_reset_en && push && stack_index == SP_FULL |=> s_over_reset)
    else $error("overflow fault reset missing");
endmodule // pcs_props

bind pcs_core pcs_props props_u (.mclk, .reset, .stack_fault_reset_en, .cmd, .pc, .stack_index, .stack_over_flag,
  .stack_under_flag, .stack_fault_reset);

// file: test/pcs_decoder_model.sv
// Core decode model: one command per call, idle between
`timescale 1ns/100ps
module pcs_decoder_model
  import pcs_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Command to the block
  output pcs_cmd_s cmd
);
  initial cmd = '0;
  // Held one edge only, since each held edge acts again
  task automatic issue(input pcs_cmd_s c);
    @(posedge mclk) cmd <= c;
    @(posedge mclk) cmd <= '0;
  endtask
endmodule // pcs_decoder_model

// file: test/program_counter_and_return_stack_bench.sv
// Bench: counter, return stack and register access
`timescale 1ns/100ps
module program_counter_and_return_stack_bench;
  import pcs_pkg::*;
  logic            mclk = 0, reset = 1, en = 0, psel = 0, penable = 0, pwrite = 0;
  logic [15:0]     paddr = '0;
  logic [31:0]     pwdata = '0, prdata, rd;
  logic            pready, pslverr, err, sfr, ovf, unf;
  logic [PC_W-1:0] pc, xpc, stk [16];
  logic [SP_W-1:0] sp, xsp;
  logic [6:0]      lat;
  pcs_cmd_s        cmd;
  int              failures = 0, checks = 0;
  always #5 mclk = ~mclk;
  pcs_decoder_model dec_u (.mclk, .cmd);
  pcs_core dut_u (.mclk, .reset, .stack_fault_reset_en(en), .cmd, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .pc, .stack_index(sp), .stack_over_flag(ovf), .stack_under_flag(unf), .stack_fault_reset(sfr));
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic apb(logic w, logic [11:0] idx, logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, 2'b00, idx, 2'b00, d};
    @(posedge mclk) penable <= 1;
    do @(posedge mclk) n++; while (pready !== 1'b1 && n < 20);
    chk(n < 20, 1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // ****
  // Reference of pc, pointer and stack
  // ****
  task automatic op(pcs_op_e o, logic [10:0] a = '0, logic [7:0] v = '0);
    logic [PC_W-1:0] n1;
    n1 = xpc + 15'h1;
    dec_u.issue('{o, a, v, v, 15'h0004});
    case (o)
      OP_CALL, OP_INDIRECT_CALL_OP, OP_INT_VECTOR: begin
        xsp = (xsp == SP_FULL) ? 5'h00 : xsp + 5'h01;
        stk[xsp[3:0]] = n1;
        xpc = (o == OP_CALL) ? {lat[6:3], a} : (o == OP_INDIRECT_CALL_OP) ? {lat, v} : 15'h0004;
      end
      OP_RETURN, OP_RET_LITERAL, OP_RET_INT: begin
        xpc = stk[xsp[3:0]];
        xsp = (xsp == SP_EMPTY) ? SP_FULL : xsp - 5'h01;
      end
      OP_BRW: xpc = n1 + {7'h00, v};
      OP_BRA: xpc = n1 + {{6{a[8]}}, a[8:0]};
      OP_PCL_WRITE: xpc = {lat, v};
      default: xpc = n1;
    endcase
    #1 chk(pc, xpc);
    chk(sp, xsp);
  endtask
  initial begin
    #200000;
    $display("FAIL %0t watchdog", $time);
    failures++;
    wrap_up;
  end
  initial begin
    repeat (20) @(posedge mclk);
    reset <= 0;
    xpc = 0;
    xsp = SP_EMPTY;
    lat = 7'h55;
    @(posedge mclk) #1 chk(pc, 0);
    apb(0, IDX_STACK_INDEX, 0);
    chk(rd, 32'h1F);
    apb(1, IDX_PC_LATCH, 32'h55);
    apb(1, IDX_PC_LOW, 32'h34);
    xpc = 15'h5534;
    #1 chk(pc, xpc);
    apb(0, IDX_PC_LOW, 0);
    chk(rd, 32'h34);
    op(OP_CALL, 11'h5A3);
    op(OP_INDIRECT_CALL_OP, 0, 8'h12);
    op(OP_BRW, 0, 8'hF0);
    op(OP_BRA, 11'h1F0);
    op(OP_INT_VECTOR);
    op(OP_PCL_WRITE, 0, 8'h9C);
    op(OP_STEP);
    apb(0, IDX_PC_LATCH, 0);
    chk(rd, 32'h55);
    apb(1, IDX_STACK_INDEX, 1);
    xsp = 5'h01;
    apb(1, IDX_TOP_LOW, 32'h66);
    stk[1][7:0] = 8'h66;
    apb(1, IDX_TOP_HIGH, 32'h2A);
    stk[1][14:8] = 7'h2A;
    apb(0, IDX_TOP_HIGH, 0);
    chk(rd, stk[1][14:8]);
    op(OP_RET_INT);
    op(OP_RET_LITERAL);
    for (int i = 0; i < 17; i++) op(OP_CALL, 11'(i));
    chk(ovf, 1);
    apb(0, IDX_TOP_LOW, 0);
    chk(rd, stk[0][7:0]);
    apb(1, IDX_STACK_INDEX, 32'h1F);
    xsp = SP_EMPTY;
    apb(0, IDX_TOP_LOW, 0);
    chk(rd, stk[15][7:0]);
    op(OP_RETURN);
    chk(unf, 1);
    apb(0, 12'h123, 0);
    chk(err, 1);
    apb(1, IDX_STATUS, 32'h3);
    apb(0, IDX_STATUS, 0);
    chk(rd, 0);
    en <= 1;
    apb(1, IDX_STACK_INDEX, 32'h1F);
    apb(0, IDX_TOP_LOW, 0);
    chk(rd, 0);
    apb(0, IDX_CTRL, 0);
    chk(rd, 1);
    dec_u.issue('{OP_RETURN, 11'h0, 8'h0, 8'h0, 15'h0});
    #1 chk(sfr, 1);
    @(posedge mclk) #1 chk({pc, sp, unf}, {15'h0, SP_EMPTY, 1'b1});
    xpc = 0;
    xsp = SP_EMPTY;
    lat = 7'h00;
    for (int i = 0; i < 16; i++) op(OP_CALL, 11'(i));
    dec_u.issue('{OP_CALL, 11'h0, 8'h0, 8'h0, 15'h0});
    #1 chk({sfr, ovf, sp}, {1'b1, 1'b1, 5'h00});
    @(posedge mclk) #1 chk({pc, sp, ovf}, {15'h0, SP_EMPTY, 1'b1});
    wrap_up;
  end
endmodule // program_counter_and_return_stack_bench
